// file: inc/adccr_consts.svh
`ifndef ADCCR_CONSTS_SVH
`define ADCCR_CONSTS_SVH
// Slave addresses of the twelve-input and four-input variants.
`define ADCCR_ADDR_WIDE 7'h35
`define ADCCR_ADDR_FOUR 7'h34
// Field positions of the written byte.
`define ADCCR_REG_BIT 7
`define ADCCR_SCAN_MSB 6
`define ADCCR_SCAN_LSB 5
`define ADCCR_CS_MSB 4
`define ADCCR_CS_LSB 1
`define ADCCR_SGL_BIT 0
`define ADCCR_SEL_MSB 6
`define ADCCR_SEL_LSB 4
`define ADCCR_CLK_BIT 3
`define ADCCR_BIP_BIT 2
`define ADCCR_RST_BIT 1
// Power-up values.
`define ADCCR_SCAN_RST 2'h0
`define ADCCR_CS_RST 4'h0
`define ADCCR_SGL_RST 1'h1
`define ADCCR_SEL_RST 3'h0
`define ADCCR_CLK_RST 1'h0
`define ADCCR_BIP_RST 1'h0
// Counts of the serial format and scan plan.
`define ADCCR_EMPTY_BITS 4'h6
`define ADCCR_BYTE_BITS 4'h8
`define ADCCR_ACK_SEEN 4'h9
`define ADCCR_REPEATS 4'h8
`define ADCCR_LAST_WIDE 4'hB
`define ADCCR_LAST_FOUR 4'h3
`define ADCCR_BASE_WIDE 4'h6
`define ADCCR_BASE_FOUR 4'h2
`endif

// file: inc/adccr_pkg.sv
package adccr_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_ACK   = 3'b010,
      ST_WRITE = 3'b011,
      ST_CONV  = 3'b100,
      ST_SEND  = 3'b101,
      ST_MACK  = 3'b110,
      ST_HOLD  = 3'b111
   } adccr_state_t;

   typedef struct packed {
      logic [1:0] scan;
      logic [3:0] cs;
      logic       sgl;
   } adccr_cfg_t;

   typedef struct packed {
      logic [2:0] sel;
      logic       ext_clk;
      logic       bipolar;
   } adccr_setup_t;

   typedef struct packed {
      logic [3:0] pos;
      logic [3:0] neg;
      logic       gnd;
   } adccr_chan_t;

   typedef struct packed {
      adccr_state_t st;
      logic [3:0]   bitn;
      logic [7:0]   sh;
      logic         rw;
      logic         dat;
      logic         byte2;
      logic         need;
      logic         sda_oe;
      logic         scl_oe;
      logic         run;
      logic         busy;
      logic [3:0]   left;
      logic [3:0]   ch;
      logic [3:0]   wr;
      logic [3:0]   rd;
      logic [3:0]   n;
      logic [9:0]   cur;
      logic         conv_start;
      adccr_chan_t  chan;
      adccr_cfg_t   cfg;
      adccr_setup_t setup;
   } adccr_ctl_t;
endpackage

// file: testbench/adccr_master_model.sv
`timescale 1ns/1ps
module adccr_master_model (
   input  wire logic clk,   // System clock.
   input  wire logic scl,   // Resolved clock wire.
   input  wire logic sda,   // Resolved data wire.
   output logic      m_scl, // Clock released when high.
   output logic      m_sda  // Data released when high.
);
   // Both lines released, so the pull-ups hold the bus idle.
   task automatic idle();
      m_scl <= 1'b1;
      m_sda <= 1'b1;
   endtask
   // One bit: low 4 cycles, high 5 cycles; a stretched clock delays the high phase.
   task automatic xbit(input logic b, output logic r);
      @(posedge clk);
      m_sda <= b;
      repeat (3) @(posedge clk);
      m_scl <= 1'b1;
      @(posedge clk);
      while (scl !== 1'b1) @(posedge clk);
      repeat (4) @(posedge clk);
      r = sda;
      m_scl <= 1'b0;
   endtask
   // Data falls while the clock is high.
   task automatic start();
      m_sda <= 1'b1;
      repeat (4) @(posedge clk);
      m_scl <= 1'b1;
      repeat (4) @(posedge clk);
      m_sda <= 1'b0;
      repeat (4) @(posedge clk);
      m_scl <= 1'b0;
   endtask
   // Data rises while the clock is high.
   task automatic stop();
      @(posedge clk);
      m_sda <= 1'b0;
      repeat (3) @(posedge clk);
      m_scl <= 1'b1;
      repeat (4) @(posedge clk);
      m_sda <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   // Eight bits out, MSB first, then the ninth clock samples the answer.
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xbit(d[i], r);
      xbit(1'b1, ack);
   endtask
   // Eight bits in; the ninth bit is low to go on or high to end reading.
   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
      xbit(nack, r);
   endtask
endmodule

// file: testbench/adccr_top_tb_top.sv
`timescale 1ns/1ps
`include "adccr_consts.svh"
module adccr_top_tb_top;
   logic                   clk, arst_n, m_scl, m_sda, a;
   logic                   res_valid = 1'b0;
   logic                   str = 1'b0;
   logic                   sda_o, sda_oe, scl_o, scl_oe, conv_start, ext, bip, res_ready;
   logic                   sda_oe4, scl_oe4;
   logic [9:0]             res_data = 10'h000;
   logic [7:0]             b0, b1;
   logic [2:0]             ref_select;
   adccr_pkg::adccr_chan_t conv_chan;
   adccr_pkg::adccr_cfg_t  cfg_state;
   adccr_pkg::adccr_cfg_t  cfg_four;
   int                     fail_count = 0;
   int                     cmp_count = 0;
   // Open-drain wires: low if any party pulls, else the pull-up wins.
   wire                    scl = m_scl & (scl_oe ? scl_o : 1'b1) & ~scl_oe4;
   wire                    sda = m_sda & (sda_oe ? sda_o : 1'b1) & ~sda_oe4;
   adccr_top dut (.clk(clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe), .conv_start(conv_start),
      .conv_chan(conv_chan), .conv_ext_clk(ext), .conv_bipolar(bip),
      .ref_select(ref_select), .cfg_state(cfg_state), .res_valid(res_valid),
      .res_data(res_data), .res_ready(res_ready));
   adccr_master_model m (.clk(clk), .scl(scl), .sda(sda), .m_scl(m_scl), .m_sda(m_sda));
   // Four-input variant on the same bus; only its write path is exercised.
   adccr_top #(.FOUR_INPUT(1'b1)) dut_four (.clk(clk), .arst_n(arst_n), .scl_i(scl),
      .sda_i(sda), .sda_o(), .sda_oe(sda_oe4), .scl_o(), .scl_oe(scl_oe4), .conv_start(),
      .conv_chan(), .conv_ext_clk(), .conv_bipolar(), .ref_select(), .cfg_state(cfg_four),
      .res_valid(1'b0), .res_data(10'h000), .res_ready());
   // Clock of 20 ns.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Converter answers one cycle later with a word that encodes the pair asked for.
   always @(posedge clk) begin
      if (res_valid && res_ready) res_valid <= 1'b0;
      if (conv_start === 1'b1) begin
         res_valid <= 1'b1;
         res_data  <= {1'b0, conv_chan.pos, conv_chan.gnd ? 4'h0 : conv_chan.neg, conv_chan.gnd};
      end
      if (scl_oe === 1'b1) str <= 1'b1;
   end
   // Verdict and end of run.
   task automatic end_of_test();
      if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Compare one value.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Whole write cycle of one byte.
   task automatic wr(input logic [7:0] d);
      m.start();
      m.wbyte({`ADCCR_ADDR_WIDE, 1'b0}, a);
      chk(16'(a), 16'h0000);
      m.wbyte(d, a);
      chk(16'(a), 16'h0000);
      m.stop();
   endtask
   // Opens a read cycle.
   task automatic rstart();
      m.start();
      m.wbyte({`ADCCR_ADDR_WIDE, 1'b1}, a);
      chk(16'(a), 16'h0000);
   endtask
   // One two-byte result; expected pair is {pos, neg, gnd}.
   task automatic rd_res(input logic [8:0] ch, input logic last);
      m.rbyte(1'b0, b0);
      m.rbyte(last, b1);
      chk({b0, b1}, {6'h3F, 1'b0, ch});
   endtask
   // After the final not-acknowledge the data line must be free.
   task automatic fin();
      repeat (4) @(posedge clk);
      chk(16'(sda_oe), 16'h0000);
      m.stop();
   endtask
   // Watchdog; the whole sequence needs well under ten thousand cycles.
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      end_of_test();
   end
   // Main sequence.
   initial begin
      arst_n    = 1'b0;
      m.idle();
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      repeat (8) @(posedge clk);
      chk(16'(cfg_state), 16'h0001);
      chk(16'(ext), 16'h0000);
      wr(8'h07);
      chk(16'(cfg_state), 16'h0007);
      rstart();
      for (int i = 0; i < 4; i++) rd_res({4'(i), 4'h0, 1'b1}, i == 3);
      chk(16'(str), 16'h0001);
      fin();
      // Even code pairs upward, odd code swaps; single and eightfold scans.
      for (int k = 0; k < 2; k++) begin
         wr(k == 1 ? 8'h26 : 8'h64);
         rstart();
         rd_res(k == 1 ? 9'h064 : 9'h046, 1'b1);
         fin();
      end
      // Shared pin as reference: scan to 11 stops at 10, then reading wraps.
      wr(8'hA2);
      wr(8'h17);
      chk(16'(ref_select), 16'h0002);
      rstart();
      for (int i = 0; i < 12; i++) rd_res({i == 11 ? 4'h0 : 4'(i), 4'h0, 1'b1}, i == 11);
      fin();
      // Setup with reset bit low, external clock and bipolar coding.
      wr(8'h8C);
      chk(16'(cfg_state), 16'h0001);
      chk(16'(ext), 16'h0001);
      chk(16'(bip), 16'h0001);
      rstart();
      for (int i = 0; i < 3; i++) rd_res(9'h001, i == 2);
      fin();
      // Foreign address is not acknowledged.
      m.start();
      m.wbyte(8'h6C, a);
      chk(16'(a), 16'h0001);
      m.stop();
      // Four-input variant clears the upper channel bits; the wide part ignores it.
      m.start();
      m.wbyte({`ADCCR_ADDR_FOUR, 1'b0}, a);
      chk(16'(a), 16'h0000);
      m.wbyte(8'h17, a);
      chk(16'(a), 16'h0000);
      m.stop();
      chk(16'(cfg_four), 16'h0007);
      chk(16'(cfg_state), 16'h0001);
      end_of_test();
   end
endmodule

// file: verilog/adccr_buf2.sv
`timescale 1ns/1ps
module adccr_buf2 #(
   parameter int W = 10,
   parameter int D = 2
) (
   input  wire logic         clk,       // System clock.
   input  wire logic         rst_n,     // Synchronised reset, active low.
   input  wire logic         in_valid,  // Word offered.
   output logic              in_ready,  // Room for a word.
   input  wire logic [W-1:0] in_data,   // Offered word.
   output logic              out_valid, // Word waiting.
   input  wire logic         out_ready, // Drain takes the word.
   output logic [W-1:0]      out_data   // Oldest word.
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   // Sized at the count's width; a pointer-wide cast of the depth would wrap to zero.
   localparam logic [AW:0] FULL = (AW + 1)'(D);

   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] wp_d;
   logic [AW-1:0] rp_q;
   logic [AW-1:0] rp_d;
   logic [AW:0]   cnt_q;
   logic [AW:0]   cnt_d;
   logic          push;
   logic          pop;

   // Flags come from the count alone, so full and empty never lie.
   assign in_ready  = (cnt_q != FULL);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rp_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointers wrap explicitly so any depth works.
   always_comb begin
      wp_d  = wp_q;
      rp_d  = rp_q;
      cnt_d = cnt_q;
      if (push) begin
         wp_d = (wp_q == AW'(D - 1)) ? '0 : wp_q + AW'(1);
      end
      if (pop) begin
         rp_d = (rp_q == AW'(D - 1)) ? '0 : rp_q + AW'(1);
      end
      if (push && !pop) begin
         cnt_d = cnt_q + (AW + 1)'(1);
      end else if (pop && !push) begin
         cnt_d = cnt_q - (AW + 1)'(1);
      end
   end

   // Pointer and count registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage needs no reset; the count marks what is valid.
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end
endmodule

// file: verilog/adccr_top.sv
// How it works
// - Written byte with bit 7 set is setup, otherwise configuration.
// - Bits 6:5 are scan select, zero after power-up.
// - Bits 4:1 are channel select, zero after power-up.
// - Four-input variant forces the upper two channel bits to zero.
// - Bit 0 picks single-ended when set; set after power-up.
// - Single-ended code n converts input n against ground; 12 to 15 reserved.
// - Differential even code pairs n with n+1; odd code swaps polarity.
// - With the shared pin used as reference, single-ended scans stop before it.
// - Device acknowledges a matching read address before sending data.
// - Each result is two bytes: six high bits, then ten bits MSB first.
// - On a not-acknowledge the device releases the data line.
// - Setup clock bit picks the clock mode; internal after power-up.
// - Clock mode picks conversion clock, timing and scan behaviour.
// - Scan 00 runs zero to selected; scan 01 repeats selected eight times.
// - Internal mode holds the serial clock low until all results are stored.
// - External mode converts continuously until the master not-acknowledges.
// - Setup byte with reset bit low restores configuration defaults only.
`timescale 1ns/1ps
`include "adccr_consts.svh"
module adccr_top #(
   parameter bit FOUR_INPUT = 1'b0
) (
   input  wire logic               clk,          // 50 MHz system clock.
   input  wire logic               arst_n,       // Asynchronous reset, active low.
   input  wire logic               scl_i,        // Serial clock pin level.
   input  wire logic               sda_i,        // Serial data pin level.
   output logic                    sda_o,        // Data drive value, always low.
   output logic                    sda_oe,       // Pulls data low when high.
   output logic                    scl_o,        // Clock drive value, always low.
   output logic                    scl_oe,       // Holds clock low when high.
   output logic                    conv_start,   // One-cycle conversion request.
   output adccr_pkg::adccr_chan_t  conv_chan,    // Input pair for that request.
   output logic                    conv_ext_clk, // Converter uses serial clock.
   output logic                    conv_bipolar, // Bipolar coding selected.
   output logic [2:0]              ref_select,   // Reference and shared pin mode.
   output adccr_pkg::adccr_cfg_t   cfg_state,    // Stored configuration fields.
   input  wire logic               res_valid,    // Converter result offered.
   input  wire logic [9:0]         res_data,     // Converter result.
   output logic                    res_ready     // Result accepted.
);
   localparam adccr_pkg::adccr_cfg_t CFG_DEF = '{scan: `ADCCR_SCAN_RST,
      cs: `ADCCR_CS_RST, sgl: `ADCCR_SGL_RST};
   localparam adccr_pkg::adccr_setup_t SETUP_DEF = '{sel: `ADCCR_SEL_RST,
      ext_clk: `ADCCR_CLK_RST, bipolar: `ADCCR_BIP_RST};
   localparam adccr_pkg::adccr_ctl_t CTL_RST = '{st: adccr_pkg::ST_IDLE,
      cfg: CFG_DEF, setup: SETUP_DEF, default: '0};
   localparam logic [6:0] ADDR = FOUR_INPUT ? `ADCCR_ADDR_FOUR : `ADCCR_ADDR_WIDE;
   localparam logic [3:0] LAST = FOUR_INPUT ? `ADCCR_LAST_FOUR : `ADCCR_LAST_WIDE;
   localparam logic [3:0] BASE = FOUR_INPUT ? `ADCCR_BASE_FOUR : `ADCCR_BASE_WIDE;

   logic [1:0]           rst_q;
   logic                 rst_n;
   logic [2:0]           scl_q;
   logic [2:0]           sda_q;
   logic                 scl_rise;
   logic                 scl_fall;
   logic                 start_c;
   logic                 stop_c;
   adccr_pkg::adccr_ctl_t ctl_q;
   adccr_pkg::adccr_ctl_t ctl_d;
   logic [9:0]           mem [12];
   logic                 mem_we;
   logic                 bv;
   logic                 bpop;
   logic [9:0]           bdata;

   // Scan plan: first channel and number of conversions.
   function automatic logic [7:0] plan(adccr_pkg::adccr_cfg_t c, adccr_pkg::adccr_setup_t s);
      logic [3:0] first;
      logic [3:0] last;
      logic [3:0] cnt;
      last = (c.cs > LAST) ? LAST : c.cs;
      if (c.sgl && s.sel[1] && last == LAST) begin
         last = LAST - 4'h1;
      end
      first = (c.scan == 2'b10) ? BASE : 4'h0;
      if (c.scan == 2'b10 && last < BASE) begin
         last = BASE;
      end
      if (c.sgl) begin
         cnt = last - first + 4'h1;
      end else begin
         cnt = {1'b0, last[3:1]} - {1'b0, first[3:1]} + 4'h1;
      end
      if (c.scan[0]) begin
         first = last;
         cnt   = c.scan[1] ? 4'h1 : `ADCCR_REPEATS;
      end
      return {first, cnt};
   endfunction

   // Channel code to input pair.
   function automatic adccr_pkg::adccr_chan_t chan_map(logic [3:0] code, logic sgl);
      adccr_pkg::adccr_chan_t m;
      m.pos = code;
      m.neg = sgl ? 4'h0 : {code[3:1], ~code[0]};
      m.gnd = sgl;
      return m;
   endfunction

   // Bit i of the outgoing byte; first byte carries the empty high bits.
   function automatic logic tx_bit(logic [9:0] w, logic b2, logic [3:0] i);
      logic [7:0] by;
      by = b2 ? w[7:0] : {6'h3F, w[9:8]};
      return by[3'h7 - i[2:0]];
   endfunction

   // Reset release and pin synchronisers; stage 2 only serves edge finding.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_q <= 2'h0;
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
         scl_q <= {scl_q[1:0], scl_i};
         sda_q <= {sda_q[1:0], sda_i};
      end
   end
   assign rst_n    = rst_q[1];
   assign scl_rise = scl_q[1] && !scl_q[2];
   assign scl_fall = !scl_q[1] && scl_q[2];
   assign start_c  = scl_q[1] && scl_q[2] && !sda_q[1] && sda_q[2];
   assign stop_c   = scl_q[1] && scl_q[2] && sda_q[1] && !sda_q[2];

   // Two-entry buffer so a stalled readout loses no converter word.
   adccr_buf2 #(.W(10), .D(2)) u_buf (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (res_valid),
      .in_ready  (res_ready),
      .in_data   (res_data),
      .out_valid (bv),
      .out_ready (bpop),
      .out_data  (bdata)
   );

   // Next state of sequencing and the serial slave.
   always_comb begin
      ctl_d            = ctl_q;
      ctl_d.conv_start = 1'b0;
      mem_we           = 1'b0;
      bpop             = !ctl_q.run && bv; // Stale words after a stop are dropped.
      if (ctl_q.run && ctl_q.setup.ext_clk && ctl_q.left == 4'h0 && !ctl_q.busy) begin
         {ctl_d.ch, ctl_d.left} = plan(ctl_q.cfg, ctl_q.setup);
      end else if (ctl_q.run && !ctl_q.busy && ctl_q.left != 4'h0) begin
         ctl_d.conv_start = 1'b1;
         ctl_d.chan       = chan_map(ctl_q.ch, ctl_q.cfg.sgl);
         ctl_d.busy       = 1'b1;
         ctl_d.left       = ctl_q.left - 4'h1;
         ctl_d.ch         = ctl_q.cfg.scan[0] ? ctl_q.ch
                          : ctl_q.ch + (ctl_q.cfg.sgl ? 4'h1 : 4'h2);
      end
      if (start_c) begin
         ctl_d.st     = adccr_pkg::ST_ADDR;
         ctl_d.bitn   = 4'h0;
         ctl_d.sda_oe = 1'b0;
         ctl_d.scl_oe = 1'b0;
         ctl_d.run    = 1'b0;
         ctl_d.busy   = 1'b0;
      end else if (stop_c) begin
         ctl_d.st     = adccr_pkg::ST_IDLE;
         ctl_d.sda_oe = 1'b0;
         ctl_d.scl_oe = 1'b0;
         ctl_d.run    = 1'b0;
         ctl_d.busy   = 1'b0;
      end else begin
         unique case (ctl_q.st)
            adccr_pkg::ST_IDLE, adccr_pkg::ST_HOLD: begin
            end
            adccr_pkg::ST_ADDR, adccr_pkg::ST_WRITE: begin
               if (scl_rise) begin
                  ctl_d.sh   = {ctl_q.sh[6:0], sda_q[1]};
                  ctl_d.bitn = ctl_q.bitn + 4'h1;
               end else if (scl_fall && ctl_q.bitn == `ADCCR_BYTE_BITS) begin
                  ctl_d.bitn = 4'h0;
                  if (ctl_q.st == adccr_pkg::ST_ADDR && ctl_q.sh[7:1] != ADDR) begin
                     ctl_d.st = adccr_pkg::ST_HOLD;
                  end else begin
                     ctl_d.sda_oe = 1'b1;
                     ctl_d.st     = adccr_pkg::ST_ACK;
                     ctl_d.dat    = (ctl_q.st == adccr_pkg::ST_WRITE);
                     ctl_d.rw     = (ctl_q.st == adccr_pkg::ST_ADDR) ? ctl_q.sh[0] : ctl_q.rw;
                  end
               end
            end
            adccr_pkg::ST_ACK: begin
               if (scl_fall) begin
                  ctl_d.sda_oe = 1'b0;
                  if (ctl_q.dat && ctl_q.sh[`ADCCR_REG_BIT]) begin
                     ctl_d.setup.sel     = ctl_q.sh[`ADCCR_SEL_MSB:`ADCCR_SEL_LSB];
                     ctl_d.setup.ext_clk = ctl_q.sh[`ADCCR_CLK_BIT];
                     ctl_d.setup.bipolar = ctl_q.sh[`ADCCR_BIP_BIT];
                     if (!ctl_q.sh[`ADCCR_RST_BIT]) begin
                        ctl_d.cfg = CFG_DEF;
                     end
                  end else if (ctl_q.dat) begin
                     ctl_d.cfg.scan = ctl_q.sh[`ADCCR_SCAN_MSB:`ADCCR_SCAN_LSB];
                     ctl_d.cfg.cs   = ctl_q.sh[`ADCCR_CS_MSB:`ADCCR_CS_LSB];
                     if (FOUR_INPUT) begin
                        ctl_d.cfg.cs[3:2] = 2'h0;
                     end
                     ctl_d.cfg.sgl = ctl_q.sh[`ADCCR_SGL_BIT];
                  end
                  if (!ctl_q.rw) begin
                     ctl_d.st = adccr_pkg::ST_WRITE;
                  end else begin
                     {ctl_d.ch, ctl_d.left} = plan(ctl_q.cfg, ctl_q.setup);
                     ctl_d.n      = ctl_d.left;
                     ctl_d.run    = 1'b1;
                     ctl_d.busy   = 1'b0;
                     ctl_d.rd     = 4'h0;
                     ctl_d.wr     = 4'h0;
                     ctl_d.byte2  = 1'b0;
                     ctl_d.need   = 1'b1;
                     ctl_d.st     = ctl_q.setup.ext_clk ? adccr_pkg::ST_SEND
                                  : adccr_pkg::ST_CONV;
                     ctl_d.scl_oe = !ctl_q.setup.ext_clk;
                  end
               end
            end
            adccr_pkg::ST_CONV: begin
               // Results fill memory while the clock is held; release after the last.
               if (ctl_q.busy && bv) begin
                  bpop       = 1'b1;
                  mem_we     = 1'b1;
                  ctl_d.busy = 1'b0;
                  ctl_d.wr   = ctl_q.wr + 4'h1;
                  if (ctl_q.left == 4'h0) begin
                     ctl_d.run    = 1'b0;
                     ctl_d.scl_oe = 1'b0;
                     ctl_d.st     = adccr_pkg::ST_SEND;
                  end
               end
            end
            adccr_pkg::ST_SEND: begin
               if (ctl_q.need) begin
                  // The first bits are always high, so loading late is harmless.
                  if (!ctl_q.setup.ext_clk) begin
                     ctl_d.cur    = mem[ctl_q.rd];
                     ctl_d.need   = 1'b0;
                     ctl_d.scl_oe = 1'b0;
                  end else if (bv) begin
                     bpop         = 1'b1;
                     ctl_d.cur    = bdata;
                     ctl_d.busy   = 1'b0;
                     ctl_d.need   = 1'b0;
                     ctl_d.scl_oe = 1'b0;
                  end else begin
                     ctl_d.scl_oe = 1'b1;
                  end
               end else if (scl_rise) begin
                  ctl_d.bitn = ctl_q.bitn + 4'h1;
               end else if (scl_fall) begin
                  if (ctl_q.bitn == `ADCCR_BYTE_BITS) begin
                     ctl_d.sda_oe = 1'b0;
                     ctl_d.st     = adccr_pkg::ST_MACK;
                  end else begin
                     ctl_d.sda_oe = !tx_bit(ctl_q.cur, ctl_q.byte2, ctl_q.bitn);
                  end
               end
            end
            adccr_pkg::ST_MACK: begin
               if (scl_rise) begin
                  if (sda_q[1]) begin
                     ctl_d.st     = adccr_pkg::ST_HOLD;
                     ctl_d.sda_oe = 1'b0;
                     ctl_d.run    = 1'b0;
                  end else begin
                     ctl_d.bitn = `ADCCR_ACK_SEEN;
                  end
               end else if (scl_fall && ctl_q.bitn == `ADCCR_ACK_SEEN) begin
                  ctl_d.bitn   = 4'h0;
                  ctl_d.byte2  = !ctl_q.byte2;
                  ctl_d.st     = adccr_pkg::ST_SEND;
                  ctl_d.sda_oe = ctl_q.byte2 ? 1'b0 : !ctl_q.cur[7];
                  if (ctl_q.byte2) begin
                     ctl_d.need = 1'b1;
                     ctl_d.rd   = (ctl_q.rd + 4'h1 == ctl_q.n) ? 4'h0 : ctl_q.rd + 4'h1;
                  end
               end
            end
         endcase
      end
   end

   // Control registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_q <= CTL_RST;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   // Result memory; contents are undefined until a scan writes them.
   always_ff @(posedge clk) begin
      if (mem_we) begin
         mem[ctl_q.wr] <= bdata;
      end
   end

   assign sda_o        = 1'b0;
   assign scl_o        = 1'b0;
   assign sda_oe       = ctl_q.sda_oe;
   assign scl_oe       = ctl_q.scl_oe;
   assign conv_start   = ctl_q.conv_start;
   assign conv_chan    = ctl_q.chan;
   assign conv_ext_clk = ctl_q.setup.ext_clk;
   assign conv_bipolar = ctl_q.setup.bipolar;
   assign ref_select   = ctl_q.setup.sel;
   assign cfg_state    = ctl_q.cfg;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   cfg_power_up_a: assert property ($rose(rst_n) |-> ctl_q.cfg == CFG_DEF
      && !ctl_q.setup.ext_clk) else $error("Defaults wrong after reset.");
   cfg_commit_a: assert property (!$stable(ctl_q.cfg) |-> $past(ctl_q.st == adccr_pkg::ST_ACK
      && scl_fall && ctl_q.dat)) else $error("Configuration changed outside commit.");
   setup_keeps_a: assert property (ctl_q.st == adccr_pkg::ST_ACK && scl_fall && ctl_q.dat
      && ctl_q.sh[7] && ctl_q.sh[1] |=> $stable(ctl_q.cfg)) else $error("Setup byte hit cfg.");
   cfg_reset_a: assert property (ctl_q.st == adccr_pkg::ST_ACK && scl_fall && ctl_q.dat
      && ctl_q.sh[7] && !ctl_q.sh[1] |=> ctl_q.cfg == CFG_DEF) else $error("No cfg reset.");
   four_input_a: assert property (FOUR_INPUT |-> ctl_q.cfg.cs[3:2] == 2'h0)
      else $error("Upper channel bits set in four-input variant.");
   addr_ack_a: assert property (ctl_q.st == adccr_pkg::ST_ADDR && scl_fall
      && ctl_q.bitn == 4'h8 && ctl_q.sh[7:1] == ADDR |=> sda_oe && ctl_q.st == adccr_pkg::ST_ACK)
      else $error("Matching address not acknowledged.");
   empty_bits_a: assert property (ctl_q.st == adccr_pkg::ST_SEND && !ctl_q.byte2
      && ctl_q.bitn < `ADCCR_EMPTY_BITS |-> !sda_oe) else $error("Empty bit driven low.");
   nack_release_a: assert property (ctl_q.st == adccr_pkg::ST_MACK && scl_rise && sda_q[1]
      && !start_c && !stop_c |=> !sda_oe [*2]) else $error("Data held after not-acknowledge.");
   conv_stretch_a: assert property (ctl_q.st == adccr_pkg::ST_CONV |-> scl_oe)
      else $error("Clock released while converting.");
   diff_pair_a: assert property (conv_start && !ctl_q.cfg.sgl |-> conv_chan.neg
      == {conv_chan.pos[3:1], ~conv_chan.pos[0]} && !conv_chan.gnd) else $error("Bad pair.");
endmodule
